//--- cifl_regs.svh
// Register offsets, field positions, reset values and masks of the interrupt flag logic.
`ifndef CIFL_REGS_SVH
`define CIFL_REGS_SVH

// ====================================================
// Register byte offsets
`define CIFL_OFS_MODE        6'h00
`define CIFL_OFS_FLAGS       6'h04
`define CIFL_OFS_STATUS      6'h08
`define CIFL_OFS_DATA_BASE   6'h0C
`define CIFL_OFS_DATA_LIMIT  6'h10
`define CIFL_OFS_INSTR_BASE  6'h14
`define CIFL_OFS_INSTR_LIMIT 6'h18
`define CIFL_OFS_TIMER_LOAD  6'h1C
`define CIFL_OFS_TIMER_COUNT 6'h20
`define CIFL_OFS_EXCH_PTR    6'h24
`define CIFL_OFS_PROG_ADDR   6'h28
`define CIFL_OFS_CPU_NUM     6'h2C

// ====================================================
// Mode register bit positions
`define CIFL_MODE_FLOAT  0
`define CIFL_MODE_CMEM   1
`define CIFL_MODE_UMEM   2
`define CIFL_MODE_ORANGE 3
`define CIFL_MODE_IPROC  4
`define CIFL_MODE_TIMER  5
`define CIFL_MODE_EXIT   6
`define CIFL_MODE_SUPER  7
`define CIFL_MODE_LEGACY 8
`define CIFL_MODE_W      9

// ====================================================
// Flag register bit positions
`define CIFL_FLAG_FLOAT  0
`define CIFL_FLAG_CMEM   1
`define CIFL_FLAG_UMEM   2
`define CIFL_FLAG_ORANGE 3
`define CIFL_FLAG_IPROC  4
`define CIFL_FLAG_TIMER  5
`define CIFL_FLAG_EXIT   6
`define CIFL_FLAG_CHAN   7
`define CIFL_FLAG_PRANGE 8
`define CIFL_FLAG_ERREXT 9
`define CIFL_FLAG_W      10

// ====================================================
// Status register fields, reset values and masks
`define CIFL_STAT_FPS      0
`define CIFL_STAT_RMODE_LO 1
`define CIFL_STAT_PORT_LO  4
`define CIFL_MODE_RESET    9'h000
`define CIFL_FLAG_RESET    10'h000
`define CIFL_SUPER_PASS    10'h246
`define CIFL_LEGACY_MASK   32'h00FFFFFF
`define CIFL_RESP_OKAY     2'h0
`define CIFL_RESP_SLVERR   2'h2

`endif

//--- cifl_pkg.sv
// Shared types of the interrupt flag logic.
`include "cifl_regs.svh"
package cifl_pkg;
	typedef logic [31:0] cifl_word_type;
	typedef logic [`CIFL_FLAG_W-1:0] cifl_flags_type;
	typedef logic [`CIFL_MODE_W-1:0] cifl_mode_type;
endpackage

//--- cifl_range_check.sv
// Address window check against a base and limit pair.
`timescale 1ns/1ps
`default_nettype none
module cifl_range_check #(
	parameter int AW = 32
) (
	input  wire logic          valid_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [AW-1:0] base_i,
	input  wire logic [AW-1:0] limit_i,
	output logic               outside_o
);
	// ====================================================
	// Elaboration check
	if (AW < 1) begin : g_bad
		$error("cifl_range_check: AW must be at least 1.");
	end

	// ====================================================
	// The limit is exclusive, so a window with base equal to limit refuses everything.
	assign outside_o = valid_i & ((addr_i < base_i) | (addr_i >= limit_i));
endmodule
`default_nettype wire

//--- cifl_interval_timer.sv
// Programmable interval counter that signals its arrival at zero.
`timescale 1ns/1ps
`default_nettype none
module cifl_interval_timer #(
	parameter int W = 32
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] value_i,
	output logic      [W-1:0] count_o,
	output logic              zero_o
);
	// ====================================================
	// Elaboration check
	if (W < 2 || W > 32) begin : g_bad
		$error("cifl_interval_timer: W must lie between 2 and 32.");
	end

	// ====================================================
	// Counter: counts down once per clock and parks at zero until reloaded.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_o <= '0;
		end else if (load_i) begin
			count_o <= value_i;
		end else if (count_o != '0) begin
			count_o <= count_o - 1'b1;
		end
	end

	// Zero pulse: one cycle when the count steps from one to zero, not while parked.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zero_o <= 1'b0;
		end else begin
			zero_o <= ~load_i & (count_o == {{(W-1){1'b0}}, 1'b1});
		end
	end
endmodule
`default_nettype wire

//--- cifl_top.sv
// Per-CPU interrupt mode, flag and exchange status logic with an AXI4-Lite register port.
// Function
// [RULE1] Any floating error sets float status bit
// [RULE2] Correctable memory error interrupts when enabled
// [RULE3] Interprocessor request sets flag when enabled
// [RULE4] Floating errors interrupt only when enabled
// [RULE5] Either channel completion sets channel flag
// [RULE6] Operand range errors interrupt when enabled
// [RULE7] Uncorrectable memory error interrupts when enabled
// [RULE8] Supervisor mode masks most; gates privileged
// [RULE9] Memory error records read mode, port
// [RULE10] Normal exit sets exit flag when enabled
// [RULE11] Normal exit always requests an exchange
// [RULE12] Data reference outside window sets flag
// [RULE13] Timer reaching zero sets flag when enabled
// [RULE14] Fetch outside instruction window sets flag
// [RULE15] Own programmable 32-bit interval counter
// [RULE16] Exchange stores own processor number
// [RULE17] Program address stored, narrower in legacy
// [RULE18] Floating range error sets float flag
// [RULE19] Exchange pointer names package first word
// [RULE20] Unmasked flag requests exchange at boundary
// [RULE21] Package load clears all flags
`timescale 1ns/1ps
`default_nettype none
`include "cifl_regs.svh"
module cifl_top #(
	parameter int                         TIMER_W = 32,
	parameter logic [7:0]                 CPU_ID  = 8'h00,
	parameter logic [`CIFL_MODE_W-1:0]    MODE_RST = `CIFL_MODE_RESET
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// AXI4-Lite slave.
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// CPU events.
	input  wire logic        float_error_i,
	input  wire logic        mem_err_corr_i,
	input  wire logic        mem_err_uncorr_i,
	input  wire logic [2:0]  mem_read_mode_i,
	input  wire logic [3:0]  mem_port_i,
	input  wire logic        fetch_valid_i,
	input  wire logic [31:0] fetch_addr_i,
	input  wire logic        operand_valid_i,
	input  wire logic [31:0] operand_addr_i,
	input  wire logic        ipi_request_i,
	input  wire logic        chan_low_done_i,
	input  wire logic        chan_high_done_i,
	input  wire logic        normal_exit_i,
	input  wire logic        error_exit_i,
	input  wire logic        instr_boundary_i,
	input  wire logic [31:0] prog_addr_i,
	input  wire logic        exchange_load_i,
	// Exchange and mode outputs.
	output logic             exchange_req_o,
	output logic [7:0]       processor_number_field_o,
	output logic [31:0]      exchange_prog_addr_o,
	output logic [31:0]      exchange_pointer_o,
	output logic             priv_allowed_o
);
	// ====================================================
	// Elaboration check
	if (TIMER_W < 2 || TIMER_W > 32) begin : g_bad
		$error("cifl_top: TIMER_W must lie between 2 and 32.");
	end

	// ====================================================
	// State
	cifl_pkg::cifl_mode_type  mode;
	cifl_pkg::cifl_flags_type flags;
	cifl_pkg::cifl_flags_type next_events;
	cifl_pkg::cifl_flags_type flag_clear;
	cifl_pkg::cifl_flags_type pass_mask;
	cifl_pkg::cifl_word_type  data_base_address;
	cifl_pkg::cifl_word_type  data_limit_address;
	cifl_pkg::cifl_word_type  instruction_base_address;
	cifl_pkg::cifl_word_type  instruction_limit_address;
	cifl_pkg::cifl_word_type  timer_reload;
	cifl_pkg::cifl_word_type  exchange_pointer;
	cifl_pkg::cifl_word_type  saved_prog_addr;
	cifl_pkg::cifl_word_type  next_rdata;
	logic                     float_error_status_bit;
	logic [2:0]               err_read_mode;
	logic [3:0]               err_port;
	logic                     operand_outside;
	logic                     fetch_outside;
	logic                     timer_zero;
	logic [TIMER_W-1:0]       timer_count;
	logic                     timer_load;
	logic                     pending;
	logic                     exch_set;
	logic [1:0]               next_rresp;
	// Write channel holding.
	logic                     aw_held;
	logic                     w_held;
	logic [5:0]               wr_addr;
	logic [31:0]              wr_data;
	logic [3:0]               wr_strb;
	logic                     wr_do;

	// ====================================================
	// Byte-lane merge of a write into an existing word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return res;
	endfunction

	// ====================================================
	// Window checks and interval counter
	cifl_range_check #(.AW(32)) u_operand_check (
		.valid_i   (operand_valid_i),
		.addr_i    (operand_addr_i),
		.base_i    (data_base_address),
		.limit_i   (data_limit_address),
		.outside_o (operand_outside)
	);

	cifl_range_check #(.AW(32)) u_fetch_check (
		.valid_i   (fetch_valid_i),
		.addr_i    (fetch_addr_i),
		.base_i    (instruction_base_address),
		.limit_i   (instruction_limit_address),
		.outside_o (fetch_outside)
	);

	// The counter is private to this CPU and runs at the system clock rate.
	cifl_interval_timer #(.W(TIMER_W)) u_timer ( // RULE15
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.load_i  (timer_load),
		.value_i (timer_reload[TIMER_W-1:0]),
		.count_o (timer_count),
		.zero_o  (timer_zero)
	);

	// ====================================================
	// AXI4-Lite write path
	// Address and data are taken in either order; the write lands once both are held.
	assign wr_do = aw_held & w_held & ~s_axi_bvalid;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_held       <= 1'b0;
			s_axi_awready <= 1'b0;
			wr_addr       <= 6'h00;
		end else if (s_axi_awvalid & s_axi_awready) begin
			aw_held       <= 1'b1;
			s_axi_awready <= 1'b0;
			wr_addr       <= s_axi_awaddr;
		end else if (wr_do) begin
			aw_held       <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_held & ~s_axi_bvalid;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w_held       <= 1'b0;
			s_axi_wready <= 1'b0;
			wr_data      <= 32'h00000000;
			wr_strb      <= 4'h0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			w_held       <= 1'b1;
			s_axi_wready <= 1'b0;
			wr_data      <= s_axi_wdata;
			wr_strb      <= s_axi_wstrb;
		end else if (wr_do) begin
			w_held       <= 1'b0;
		end else begin
			s_axi_wready <= ~w_held & ~s_axi_bvalid;
		end
	end

	// Write response; unmapped or read-only offsets answer SLVERR.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CIFL_RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			unique case (wr_addr)
				`CIFL_OFS_MODE, `CIFL_OFS_FLAGS, `CIFL_OFS_DATA_BASE, `CIFL_OFS_DATA_LIMIT,
				`CIFL_OFS_INSTR_BASE, `CIFL_OFS_INSTR_LIMIT, `CIFL_OFS_TIMER_LOAD,
				`CIFL_OFS_EXCH_PTR: s_axi_bresp <= `CIFL_RESP_OKAY;
				default: s_axi_bresp <= `CIFL_RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ====================================================
	// Software-written registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= MODE_RST;
		end else if (wr_do && wr_addr == `CIFL_OFS_MODE) begin
			mode <= cifl_pkg::cifl_mode_type'(merge({23'h000000, mode}, wr_data, wr_strb));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_base_address         <= 32'h00000000;
			data_limit_address        <= 32'h00000000;
			instruction_base_address  <= 32'h00000000;
			instruction_limit_address <= 32'h00000000;
			exchange_pointer          <= 32'h00000000;
		end else if (wr_do) begin
			unique case (wr_addr)
				`CIFL_OFS_DATA_BASE:
					data_base_address <= merge(data_base_address, wr_data, wr_strb);
				`CIFL_OFS_DATA_LIMIT:
					data_limit_address <= merge(data_limit_address, wr_data, wr_strb);
				`CIFL_OFS_INSTR_BASE:
					instruction_base_address <= merge(instruction_base_address, wr_data, wr_strb);
				`CIFL_OFS_INSTR_LIMIT:
					instruction_limit_address <= merge(instruction_limit_address, wr_data, wr_strb);
				`CIFL_OFS_EXCH_PTR:
					exchange_pointer <= merge(exchange_pointer, wr_data, wr_strb); // RULE19
				default: ;
			endcase
		end
	end

	// A write to the reload word also restarts the counter from that value.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_reload <= 32'h00000000;
			timer_load   <= 1'b0;
		end else begin
			timer_load <= wr_do && wr_addr == `CIFL_OFS_TIMER_LOAD;
			if (wr_do && wr_addr == `CIFL_OFS_TIMER_LOAD) begin
				timer_reload <= merge(timer_reload, wr_data, wr_strb);
			end
		end
	end

	// ====================================================
	// Flag events
	// Each flag but the channel, fetch range and error exit flags is gated by its mode bit here; supervisor masking acts on the request instead.
	always_comb begin
		next_events = '0;
		next_events[`CIFL_FLAG_FLOAT]  = float_error_i & mode[`CIFL_MODE_FLOAT]; // RULE4 RULE18
		next_events[`CIFL_FLAG_CMEM]   = mem_err_corr_i & mode[`CIFL_MODE_CMEM]; // RULE2
		next_events[`CIFL_FLAG_UMEM]   = mem_err_uncorr_i & mode[`CIFL_MODE_UMEM]; // RULE7
		next_events[`CIFL_FLAG_ORANGE] = operand_outside & mode[`CIFL_MODE_ORANGE]; // RULE6 RULE12
		next_events[`CIFL_FLAG_IPROC]  = ipi_request_i & mode[`CIFL_MODE_IPROC]; // RULE3
		next_events[`CIFL_FLAG_TIMER]  = timer_zero & mode[`CIFL_MODE_TIMER]; // RULE13
		next_events[`CIFL_FLAG_EXIT]   = normal_exit_i & mode[`CIFL_MODE_EXIT]; // RULE10
		next_events[`CIFL_FLAG_CHAN]   = chan_low_done_i | chan_high_done_i; // RULE5
		next_events[`CIFL_FLAG_PRANGE] = fetch_outside; // RULE14
		next_events[`CIFL_FLAG_ERREXT] = error_exit_i;
	end

	// Software clears a flag by writing one to it; a package load clears them all.
	always_comb begin
		flag_clear = {`CIFL_FLAG_W{exchange_load_i}}; // RULE21
		if (wr_do && wr_addr == `CIFL_OFS_FLAGS) begin
			flag_clear = flag_clear | wr_data[`CIFL_FLAG_W-1:0];
		end
	end

	// One flip-flop per flag; a new event wins over a clear in the same cycle.
	for (genvar i = 0; i < `CIFL_FLAG_W; i++) begin : g_flag
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				flags[i] <= 1'((`CIFL_FLAG_RESET) >> i);
			end else if (next_events[i]) begin
				flags[i] <= 1'b1;
			end else if (flag_clear[i]) begin
				flags[i] <= 1'b0;
			end
		end
	end

	// ====================================================
	// Status field
	// The float status bit sees every floating error, whatever the mode bit says.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			float_error_status_bit <= 1'b0;
		end else if (float_error_i) begin
			float_error_status_bit <= 1'b1; // RULE1
		end else if (exchange_load_i) begin
			float_error_status_bit <= 1'b0;
		end
	end

	// The most recent memory error overwrites the recorded mode and port.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_read_mode <= 3'h0;
			err_port      <= 4'h0;
		end else if (mem_err_corr_i | mem_err_uncorr_i) begin
			err_read_mode <= mem_read_mode_i; // RULE9
			err_port      <= mem_port_i;
		end
	end

	// ====================================================
	// Exchange request
	// In supervisor mode only memory errors and the two exits may reach the request.
	assign pass_mask = mode[`CIFL_MODE_SUPER] ? `CIFL_SUPER_PASS : '1; // RULE8
	assign pending   = |(flags & pass_mask); // RULE20
	// Exits request at once; other flags wait for a boundary, not the load cycle itself.
	assign exch_set  = normal_exit_i | error_exit_i | // RULE11
		(instr_boundary_i & pending & ~exchange_load_i); // RULE20

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			exchange_req_o <= 1'b0;
		end else if (exch_set) begin
			exchange_req_o <= 1'b1;
		end else if (exchange_load_i) begin
			exchange_req_o <= 1'b0;
		end
	end

	// The stored program address is captured as the request rises.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			saved_prog_addr <= 32'h00000000;
		end else if (exch_set & ~exchange_req_o) begin
			saved_prog_addr <= mode[`CIFL_MODE_LEGACY] ? // RULE17
				(prog_addr_i & `CIFL_LEGACY_MASK) : prog_addr_i;
		end
	end

	// Package-facing outputs, each from its own flop.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			processor_number_field_o <= 8'h00;
			exchange_prog_addr_o     <= 32'h00000000;
			exchange_pointer_o       <= 32'h00000000;
			priv_allowed_o           <= 1'b0;
		end else begin
			processor_number_field_o <= CPU_ID; // RULE16
			exchange_prog_addr_o     <= saved_prog_addr;
			exchange_pointer_o       <= exchange_pointer; // RULE19
			priv_allowed_o           <= mode[`CIFL_MODE_SUPER]; // RULE8
		end
	end

	// ====================================================
	// AXI4-Lite read path
	always_comb begin
		next_rdata = 32'h00000000;
		next_rresp = `CIFL_RESP_OKAY;
		unique case (s_axi_araddr)
			`CIFL_OFS_MODE:        next_rdata[`CIFL_MODE_W-1:0] = mode;
			`CIFL_OFS_FLAGS:       next_rdata[`CIFL_FLAG_W-1:0] = flags;
			`CIFL_OFS_STATUS: begin
				next_rdata[`CIFL_STAT_FPS] = float_error_status_bit;
				next_rdata[`CIFL_STAT_RMODE_LO +: 3] = err_read_mode;
				next_rdata[`CIFL_STAT_PORT_LO +: 4] = err_port;
			end
			`CIFL_OFS_DATA_BASE:   next_rdata = data_base_address;
			`CIFL_OFS_DATA_LIMIT:  next_rdata = data_limit_address;
			`CIFL_OFS_INSTR_BASE:  next_rdata = instruction_base_address;
			`CIFL_OFS_INSTR_LIMIT: next_rdata = instruction_limit_address;
			`CIFL_OFS_TIMER_LOAD:  next_rdata = timer_reload;
			`CIFL_OFS_TIMER_COUNT: next_rdata[TIMER_W-1:0] = timer_count;
			`CIFL_OFS_EXCH_PTR:    next_rdata = exchange_pointer;
			`CIFL_OFS_PROG_ADDR:   next_rdata = saved_prog_addr;
			`CIFL_OFS_CPU_NUM:     next_rdata[7:0] = CPU_ID;
			default:               next_rresp = `CIFL_RESP_SLVERR;
		endcase
	end

	// One read at a time: arready drops while an answer waits.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `CIFL_RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- cifl_event_model.sv
// Model of the event sources around the block: other CPUs, channels, memory and issue logic.
`timescale 1ns/1ps
`default_nettype none
module cifl_event_model (
	input  wire logic        clk_i,
	input  wire logic [11:0] go_i,
	output logic      [11:0] ev_o = 12'h000
);
	// ==========================================================
	// Event launch
	// One-cycle pulses; a held level would hide a missing clear.
	always_ff @(posedge clk_i) begin
		ev_o <= go_i;
	end
endmodule
`default_nettype wire

//--- cifl_monitor.sv
// Bus and exchange request checker for the interrupt flag logic.
`timescale 1ns/1ps
`default_nettype none
module cifl_monitor #(
	parameter logic [7:0] CPU_ID = 8'h00
) (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       normal_exit_i,
	input wire logic       error_exit_i,
	input wire logic       instr_boundary_i,
	input wire logic       exchange_load_i,
	input wire logic       exchange_req_o,
	input wire logic [7:0] processor_number_field_o
);
	// ==========================================================
	// Properties
	// One clock; reset silences all.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	exit_req_a: assert property ((normal_exit_i || error_exit_i) |=> exchange_req_o)
		else $error("exit without request");
	req_hold_a: assert property (exchange_req_o && !exchange_load_i |=> exchange_req_o)
		else $error("request dropped");
	load_clear_a: assert property (exchange_load_i && !normal_exit_i && !error_exit_i
		&& !instr_boundary_i |=> !exchange_req_o) else $error("load left request up");
	req_cause_a: assert property ($rose(exchange_req_o) |->
		$past(normal_exit_i || error_exit_i || instr_boundary_i)) else $error("request from nothing");
	cpu_num_a: assert property (!rst_i |=> processor_number_field_o == CPU_ID)
		else $error("processor number wrong");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bresp not held");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rdata not held");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	ready_low_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("ready during response");
	exit_c: cover property (normal_exit_i ##1 exchange_req_o);
	load_c: cover property (exchange_req_o && exchange_load_i);
	bresp_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
endmodule
bind cifl_top cifl_monitor #(.CPU_ID(CPU_ID)) u_mon (.clk_i, .rst_i, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .normal_exit_i, .error_exit_i, .instr_boundary_i,
	.exchange_load_i, .exchange_req_o, .processor_number_field_o);
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the interrupt flag logic.
`timescale 1ns/1ps
`default_nettype none
`include "cifl_regs.svh"
module testbench;
	localparam logic [7:0] ID = 8'h5A; // Arbitrary processor number.
	logic        clk_i = 1'b0, rst_i = 1'b1;
	logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, req, priv;
	logic [1:0]  bresp, rresp;
	logic [31:0] wdata = 32'h0, rdata, epa, xp, paddr = 32'h0, faddr = 32'h0, oaddr = 32'h0;
	logic [2:0]  mrm = 3'h0;
	logic [3:0]  mport = 4'h0;
	logic [7:0]  pn;
	logic [11:0] go = 12'h000, ev;
	int          n_fail = 0, comparisons = 0, cyc = 0;
	// ==========================================================
	// Clock, watchdog, partner and design
	always #5 clk_i = ~clk_i;
	// A hang counts as a mismatch.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end
	cifl_event_model u_src (.clk_i, .go_i(go), .ev_o(ev));
	cifl_top #(.CPU_ID(ID)) DUT (.clk_i, .rst_i, .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .float_error_i(ev[0]), .mem_err_corr_i(ev[1]),
		.mem_err_uncorr_i(ev[2]), .mem_read_mode_i(mrm), .mem_port_i(mport),
		.fetch_valid_i(ev[10]), .fetch_addr_i(faddr), .operand_valid_i(ev[11]),
		.operand_addr_i(oaddr), .ipi_request_i(ev[3]), .chan_low_done_i(ev[4]),
		.chan_high_done_i(ev[5]), .normal_exit_i(ev[6]), .error_exit_i(ev[7]),
		.instr_boundary_i(ev[8]), .prog_addr_i(paddr), .exchange_load_i(ev[9]),
		.exchange_req_o(req), .processor_number_field_o(pn), .exchange_prog_addr_o(epa),
		.exchange_pointer_o(xp), .priv_allowed_o(priv));
	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d,
			input logic [1:0] er = `CIFL_RESP_OKAY);
		logic aw = 1'b0, w = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk_i);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_i); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", 32'(bresp), 32'(er));
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] e,
			input logic [1:0] er = `CIFL_RESP_OKAY);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_i); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rdata", rdata, e);
		chk("rresp", 32'(rresp), 32'(er));
		@(posedge clk_i);
	endtask
	// Pulses events via the partner; flags settle.
	task evt(input logic [11:0] g);
		go <= g;
		@(posedge clk_i);
		go <= 12'h000;
		repeat (3) @(posedge clk_i);
	endtask
	task test_done();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task t_reset();
		rdc(`CIFL_OFS_MODE, 32'h0);
		rdc(`CIFL_OFS_CPU_NUM, 32'(ID));
		rdc(6'h30, 32'h0, `CIFL_RESP_SLVERR);
		wr(`CIFL_OFS_STATUS, 32'hFF, `CIFL_RESP_SLVERR);
		rdc(`CIFL_OFS_STATUS, 32'h0);
	endtask
	task t_float();
		wr(`CIFL_OFS_MODE, 32'h1);
		evt(12'h001);
		rdc(`CIFL_OFS_FLAGS, 32'h1);
		evt(12'h200);
		wr(`CIFL_OFS_MODE, 32'h0);
		evt(12'h001);
		rdc(`CIFL_OFS_FLAGS, 32'h0);
		rdc(`CIFL_OFS_STATUS, 32'h1);
	endtask
	task t_mem();
		evt(12'h200);
		mrm <= 3'h5;
		mport <= 4'hA;
		wr(`CIFL_OFS_MODE, 32'h2);
		evt(12'h006);
		rdc(`CIFL_OFS_FLAGS, 32'h2);
		rdc(`CIFL_OFS_STATUS, 32'hAA);
		wr(`CIFL_OFS_MODE, 32'h4);
		evt(12'h004);
		rdc(`CIFL_OFS_FLAGS, 32'h6);
	endtask
	task t_chan_range();
		evt(12'h200);
		evt(12'h010);
		rdc(`CIFL_OFS_FLAGS, 32'h80);
		wr(`CIFL_OFS_FLAGS, 32'h80);
		evt(12'h020);
		rdc(`CIFL_OFS_FLAGS, 32'h80);
		evt(12'h200);
		wr(`CIFL_OFS_DATA_BASE, 32'h100);
		wr(`CIFL_OFS_DATA_LIMIT, 32'h200);
		wr(`CIFL_OFS_INSTR_BASE, 32'h1000);
		wr(`CIFL_OFS_INSTR_LIMIT, 32'h2000);
		wr(`CIFL_OFS_MODE, 32'h8);
		oaddr <= 32'h1FF;
		faddr <= 32'h1000;
		evt(12'hC00);
		rdc(`CIFL_OFS_FLAGS, 32'h0);
		oaddr <= 32'h200;
		faddr <= 32'hFFF;
		evt(12'hC00);
		rdc(`CIFL_OFS_FLAGS, 32'h108);
	endtask
	task t_super();
		evt(12'h200);
		wr(`CIFL_OFS_MODE, 32'h90);
		chk("priv", 32'(priv), 32'h1);
		evt(12'h008);
		evt(12'h100);
		chk("req", 32'(req), 32'h0);
		rdc(`CIFL_OFS_FLAGS, 32'h10);
		wr(`CIFL_OFS_MODE, 32'h94);
		evt(12'h004);
		evt(12'h100);
		chk("req", 32'(req), 32'h1);
		evt(12'h200);
		chk("req", 32'(req), 32'h0);
		rdc(`CIFL_OFS_FLAGS, 32'h0);
	endtask
	task t_exit();
		paddr <= 32'h12345678;
		wr(`CIFL_OFS_MODE, 32'h40);
		evt(12'h040);
		chk("req", 32'(req), 32'h1);
		chk("epa", epa, 32'h12345678);
		rdc(`CIFL_OFS_FLAGS, 32'h40);
		evt(12'h200);
		wr(`CIFL_OFS_MODE, 32'h100);
		evt(12'h040);
		chk("req", 32'(req), 32'h1);
		chk("epa", epa, 32'h00345678);
		rdc(`CIFL_OFS_FLAGS, 32'h0);
		evt(12'h200);
		evt(12'h080);
		chk("req", 32'(req), 32'h1);
		wr(`CIFL_OFS_EXCH_PTR, 32'h00ABCDE0);
		@(posedge clk_i);
		chk("xp", xp, 32'h00ABCDE0);
	endtask
	task t_timer();
		evt(12'h200);
		wr(`CIFL_OFS_MODE, 32'h20);
		wr(`CIFL_OFS_TIMER_LOAD, 32'h5);
		rdc(`CIFL_OFS_FLAGS, 32'h0);
		repeat (12) @(posedge clk_i);
		rdc(`CIFL_OFS_FLAGS, 32'h20);
	endtask
	// Reset for twelve cycles, then each scenario once.
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_reset();
		t_float();
		t_mem();
		t_chan_range();
		t_super();
		t_exit();
		t_timer();
		test_done();
	end
endmodule
`default_nettype wire
